// ==== ebs_brake_model.sv ====
// external brake model with a confirmation contact
`default_nettype none
module ebs_brake_model #(
  parameter int unsigned DLY = 6
) (
  input wire logic mclk,
  input wire logic release_cmd,
  input wire logic [1:0] mode,
  output logic confirm
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DLY-1:0] pipe = '0;
  // mechanical delay between command and contact
  always @(posedge mclk) begin
    pipe <= {pipe[DLY-2:0], release_cmd};
  end
  // 0 healthy, 1 contact stuck open, 2 contact stuck closed
  always_comb begin
    case (mode)
      2'h1: confirm = 1'b0;
      2'h2: confirm = 1'b1;
      default: confirm = pipe[DLY-1];
    endcase
  end
endmodule // ebs_brake_model
`default_nettype wire

// ==== ebs_pkg.sv ====
// shared constants, register map and carrier types of the external brake sequencer
`default_nettype none
package ebs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_PERIOD_NS = 10_000_000;
  localparam int unsigned TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PRE_W = 20;
  localparam logic [8:0] WAIT_MAX = 9'h1f4;

  ////////////////////////////////////////////////////////////////////////////
  // codes
  localparam logic [1:0] BRAKE_EN_ON = 2'h1;
  localparam logic [7:0] FN_CONFIRM = 8'h2c;
  localparam logic [5:0] FN_RELEASE = 6'h13;
  localparam logic [5:0] FN_ERROR = 6'h14;
  localparam int unsigned N_IN = 8;
  localparam int unsigned N_OUT = 5;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_REL_WAIT = 8'h04;
  localparam logic [7:0] OFS_ACC_WAIT = 8'h08;
  localparam logic [7:0] OFS_STOP_WAIT = 8'h0c;
  localparam logic [7:0] OFS_CONF_WAIT = 8'h10;
  localparam logic [7:0] OFS_REL_FREQ = 8'h14;
  localparam logic [7:0] OFS_REL_CUR = 8'h18;
  localparam logic [7:0] OFS_BRK_FREQ = 8'h1c;
  localparam logic [7:0] OFS_IN_FN_LO = 8'h20;
  localparam logic [7:0] OFS_IN_FN_HI = 8'h24;
  localparam logic [7:0] OFS_OUT_FN = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2c;
  localparam logic [7:0] OFS_INT_STAT = 8'h30;
  localparam logic [7:0] OFS_INT_MASK = 8'h34;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned CTRL_TRIP_CLR_BIT = 8;
  localparam int unsigned ST_REL_BIT = 16;
  localparam int unsigned ST_ERR_BIT = 17;
  localparam int unsigned ST_CONF_BIT = 18;
  localparam int unsigned ST_ASGN_BIT = 19;
  localparam int unsigned INT_REL_ON = 0;
  localparam int unsigned INT_REL_OFF = 1;
  localparam int unsigned INT_TRIP = 2;
  localparam int unsigned INT_DONE = 3;
  localparam int unsigned N_INT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [8:0] WAIT_RST = 9'h000;
  localparam logic [15:0] FREQ_RST = 16'h0000;
  localparam logic [15:0] CUR_RST = 16'h0000;
  localparam logic [63:0] IN_FN_RST = 64'h0000_0000_0000_0000;
  localparam logic [29:0] OUT_FN_RST = 30'h0000_0000;
  localparam logic [3:0] INT_RST = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [10:0] {
    ST_IDLE       = 11'h001,
    ST_RAMP_REL   = 11'h002,
    ST_REL_WAIT   = 11'h004,
    ST_CONF_ON    = 11'h008,
    ST_ACC_WAIT   = 11'h010,
    ST_RUNNING    = 11'h020,
    ST_DECEL_BRK  = 11'h040,
    ST_CONF_OFF   = 11'h080,
    ST_STOP_WAIT  = 11'h100,
    ST_STOP_DECEL = 11'h200,
    ST_TRIP       = 11'h400
  } ebs_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ebs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ebs_apb_rsp_t;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [8:0] ticks;
  } ebs_tmr_t;

  typedef struct packed {
    ebs_state_t st;
    logic [1:0] brake_ctrl_enable;
    logic [8:0] release_wait_time;
    logic [8:0] accel_wait_time;
    logic [8:0] stop_wait_time;
    logic [8:0] confirm_wait_time;
    logic [15:0] release_frequency;
    logic [15:0] release_current;
    logic [15:0] braking_frequency;
    logic [63:0] in_fn;
    logic [29:0] out_fn;
    logic [3:0] int_stat;
    logic [3:0] int_mask;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic brake_rel;
    logic brake_err;
    logic drive_run;
    logic [15:0] freq_target;
    logic [4:0] term_out;
    logic [31:0] prdata;
  } ebs_core_t;

endpackage
`default_nettype wire

// ==== ebs_seq.sv ====
// brake sequencer: state machine, apb registers, interrupt and terminal routing
`default_nettype none

// Functional notes
// - Sequence runs only when enable equals 01
// - Run: start output, ramp to release frequency
// - After release wait, assert brake release
// - Current low at wait end: trip, error
// - Code 44 assigned: hold, await confirmation
// - No confirmation within wait: trip, error
// - Unassigned confirmation: go straight to acceleration wait
// - After confirmation, accel wait, then ramp
// - Run off: decelerate to braking frequency, release off
// - Confirmation must drop within wait, else trip
// - Unassigned confirmation: skip stop check
// - After stop wait, decelerate to 0 Hz
// - Confirmation lost while released: trip, error
// - Wait times 0.00 to 5.00 s
module ebs_seq #(
  parameter int unsigned TICK_CYCLES = ebs_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire ebs_pkg::ebs_apb_req_t apb_req,
  output ebs_pkg::ebs_apb_rsp_t apb_rsp,
  input wire logic run_cmd,
  input wire logic [15:0] freq_cmd,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] out_current,
  input wire logic [7:0] term_in,
  output logic drive_run,
  output logic [15:0] freq_target,
  output logic brake_release_out,
  output logic brake_error_out,
  output logic [4:0] term_out,
  output logic irq
);
  import ebs_pkg::*;

  localparam ebs_core_t CORE_RST = '{
    st: ST_IDLE,
    brake_ctrl_enable: CTRL_RST,
    release_wait_time: WAIT_RST,
    accel_wait_time: WAIT_RST,
    stop_wait_time: WAIT_RST,
    confirm_wait_time: WAIT_RST,
    release_frequency: FREQ_RST,
    release_current: CUR_RST,
    braking_frequency: FREQ_RST,
    in_fn: IN_FN_RST,
    out_fn: OUT_FN_RST,
    int_stat: INT_RST,
    int_mask: INT_RST,
    sync1: 8'h00,
    sync2: 8'h00,
    brake_rel: 1'b0,
    brake_err: 1'b0,
    drive_run: 1'b0,
    freq_target: FREQ_RST,
    term_out: 5'h00,
    prdata: 32'h0000_0000
  };

  ebs_core_t core_reg;
  ebs_core_t core_next;

  logic [N_IN-1:0] conf_assigned_vec;
  logic [N_IN-1:0] conf_hit_vec;
  logic [N_OUT-1:0] out_is_rel;
  logic [N_OUT-1:0] out_is_err;
  logic conf_assigned;
  logic brake_confirm_in;
  logic enabled;
  logic tmr_restart;
  logic tmr_halt;
  logic tmr_done;
  logic [8:0] tmr_limit;
  logic wr_en;
  logic setup;
  logic addr_hit;
  logic [31:0] rd_data;
  logic [3:0] ev;
  logic [3:0] w1c;
  logic trip_clear;

  ////////////////////////////////////////////////////////////////////////////
  // terminal function decode
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_in
      assign conf_assigned_vec[gi] = (core_reg.in_fn[gi*8 +: 8] == FN_CONFIRM);
      assign conf_hit_vec[gi] = conf_assigned_vec[gi] & core_reg.sync2[gi];
    end
    for (gi = 0; gi < N_OUT; gi++) begin : g_out
      assign out_is_rel[gi] = (core_reg.out_fn[gi*6 +: 6] == FN_RELEASE);
      assign out_is_err[gi] = (core_reg.out_fn[gi*6 +: 6] == FN_ERROR);
    end
  endgenerate

  assign conf_assigned = |conf_assigned_vec;
  assign brake_confirm_in = |conf_hit_vec;
  assign enabled = (core_reg.brake_ctrl_enable == BRAKE_EN_ON);

  ////////////////////////////////////////////////////////////////////////////
  // wait timer
  always_comb begin
    case (core_reg.st)
      ST_REL_WAIT: tmr_limit = core_reg.release_wait_time;
      ST_CONF_ON: tmr_limit = core_reg.confirm_wait_time;
      ST_CONF_OFF: tmr_limit = core_reg.confirm_wait_time;
      ST_ACC_WAIT: tmr_limit = core_reg.accel_wait_time;
      ST_STOP_WAIT: tmr_limit = core_reg.stop_wait_time;
      default: tmr_limit = WAIT_RST;
    endcase
  end

  assign tmr_restart = (core_next.st != core_reg.st);
  assign tmr_halt = (core_reg.st == ST_TRIP);

  ebs_wait_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .restart(tmr_restart),
    .halt(tmr_halt),
    .limit(tmr_limit),
    .done(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  assign setup = apb_req.psel & ~apb_req.penable;
  assign wr_en = ce & apb_req.psel & apb_req.penable & apb_req.pwrite & addr_hit;

  always_comb begin
    rd_data = 32'h0000_0000;
    addr_hit = 1'b1;
    if (apb_req.paddr == OFS_CTRL) begin
      rd_data[1:0] = core_reg.brake_ctrl_enable;
    end else if (apb_req.paddr == OFS_REL_WAIT) begin
      rd_data[8:0] = core_reg.release_wait_time;
    end else if (apb_req.paddr == OFS_ACC_WAIT) begin
      rd_data[8:0] = core_reg.accel_wait_time;
    end else if (apb_req.paddr == OFS_STOP_WAIT) begin
      rd_data[8:0] = core_reg.stop_wait_time;
    end else if (apb_req.paddr == OFS_CONF_WAIT) begin
      rd_data[8:0] = core_reg.confirm_wait_time;
    end else if (apb_req.paddr == OFS_REL_FREQ) begin
      rd_data[15:0] = core_reg.release_frequency;
    end else if (apb_req.paddr == OFS_REL_CUR) begin
      rd_data[15:0] = core_reg.release_current;
    end else if (apb_req.paddr == OFS_BRK_FREQ) begin
      rd_data[15:0] = core_reg.braking_frequency;
    end else if (apb_req.paddr == OFS_IN_FN_LO) begin
      rd_data = core_reg.in_fn[31:0];
    end else if (apb_req.paddr == OFS_IN_FN_HI) begin
      rd_data = core_reg.in_fn[63:32];
    end else if (apb_req.paddr == OFS_OUT_FN) begin
      rd_data[29:0] = core_reg.out_fn;
    end else if (apb_req.paddr == OFS_STATUS) begin
      rd_data[10:0] = core_reg.st;
      rd_data[ST_REL_BIT] = core_reg.brake_rel;
      rd_data[ST_ERR_BIT] = core_reg.brake_err;
      rd_data[ST_CONF_BIT] = brake_confirm_in;
      rd_data[ST_ASGN_BIT] = conf_assigned;
    end else if (apb_req.paddr == OFS_INT_STAT) begin
      rd_data[N_INT-1:0] = core_reg.int_stat;
    end else if (apb_req.paddr == OFS_INT_MASK) begin
      rd_data[N_INT-1:0] = core_reg.int_mask;
    end else begin
      addr_hit = 1'b0;
    end
  end

  assign trip_clear = wr_en & (apb_req.paddr == OFS_CTRL) & apb_req.pwdata[CTRL_TRIP_CLR_BIT];
  assign w1c = (wr_en && (apb_req.paddr == OFS_INT_STAT)) ? apb_req.pwdata[N_INT-1:0] : INT_RST;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    core_next = core_reg;
    ev = INT_RST;

    // two-stage sync of terminal pins
    core_next.sync1 = term_in;
    core_next.sync2 = core_reg.sync1;

    // register writes
    if (wr_en) begin
      if (apb_req.paddr == OFS_CTRL) begin
        core_next.brake_ctrl_enable = apb_req.pwdata[1:0];
      end else if (apb_req.paddr == OFS_REL_WAIT) begin
        core_next.release_wait_time = wait_clamp(apb_req.pwdata);
      end else if (apb_req.paddr == OFS_ACC_WAIT) begin
        core_next.accel_wait_time = wait_clamp(apb_req.pwdata);
      end else if (apb_req.paddr == OFS_STOP_WAIT) begin
        core_next.stop_wait_time = wait_clamp(apb_req.pwdata);
      end else if (apb_req.paddr == OFS_CONF_WAIT) begin
        core_next.confirm_wait_time = wait_clamp(apb_req.pwdata);
      end else if (apb_req.paddr == OFS_REL_FREQ) begin
        core_next.release_frequency = apb_req.pwdata[15:0];
      end else if (apb_req.paddr == OFS_REL_CUR) begin
        core_next.release_current = apb_req.pwdata[15:0];
      end else if (apb_req.paddr == OFS_BRK_FREQ) begin
        core_next.braking_frequency = apb_req.pwdata[15:0];
      end else if (apb_req.paddr == OFS_IN_FN_LO) begin
        core_next.in_fn[31:0] = apb_req.pwdata;
      end else if (apb_req.paddr == OFS_IN_FN_HI) begin
        core_next.in_fn[63:32] = apb_req.pwdata;
      end else if (apb_req.paddr == OFS_OUT_FN) begin
        core_next.out_fn = apb_req.pwdata[29:0];
      end else if (apb_req.paddr == OFS_INT_MASK) begin
        core_next.int_mask = apb_req.pwdata[N_INT-1:0];
      end
    end

    // sequencer
    case (core_reg.st)
      ST_IDLE: begin
        if (enabled && run_cmd) begin
          core_next.st = ST_RAMP_REL;
        end
      end
      ST_RAMP_REL: begin
        if (!run_cmd) begin
          core_next.st = ST_STOP_DECEL;
        end else if (out_freq >= core_reg.release_frequency) begin
          core_next.st = ST_REL_WAIT;
        end
      end
      ST_REL_WAIT: begin
        if (!run_cmd) begin
          core_next.st = ST_STOP_DECEL;
        end else if (tmr_done) begin
          if (out_current < core_reg.release_current) begin
            core_next.st = ST_TRIP;
          end else begin
            core_next.brake_rel = 1'b1;
            core_next.st = conf_assigned ? ST_CONF_ON : ST_ACC_WAIT;
          end
        end
      end
      ST_CONF_ON: begin
        if (brake_confirm_in) begin
          core_next.st = ST_ACC_WAIT;
        end else if (tmr_done) begin
          core_next.st = ST_TRIP;
        end
      end
      ST_ACC_WAIT: begin
        if (!run_cmd) begin
          core_next.st = ST_DECEL_BRK;
        end else if (tmr_done) begin
          core_next.st = ST_RUNNING;
        end
      end
      ST_RUNNING: begin
        if (!run_cmd) begin
          core_next.st = ST_DECEL_BRK;
        end
      end
      ST_DECEL_BRK: begin
        if (out_freq <= core_reg.braking_frequency) begin
          core_next.brake_rel = 1'b0;
          core_next.st = conf_assigned ? ST_CONF_OFF : ST_STOP_WAIT;
        end
      end
      ST_CONF_OFF: begin
        if (!brake_confirm_in) begin
          core_next.st = ST_STOP_WAIT;
        end else if (tmr_done) begin
          core_next.st = ST_TRIP;
        end
      end
      ST_STOP_WAIT: begin
        if (tmr_done) begin
          core_next.st = ST_STOP_DECEL;
        end
      end
      ST_STOP_DECEL: begin
        if (out_freq == FREQ_RST) begin
          core_next.st = ST_IDLE;
          ev[INT_DONE] = 1'b1;
        end
      end
      ST_TRIP: begin
        if (trip_clear) begin
          core_next.st = ST_IDLE;
        end
      end
      default: begin
        core_next.st = ST_IDLE;
      end
    endcase

    // confirmation lost while release is held
    if (conf_assigned && core_reg.brake_rel && !brake_confirm_in &&
        ((core_reg.st == ST_ACC_WAIT) || (core_reg.st == ST_RUNNING) || (core_reg.st == ST_DECEL_BRK))) begin
      core_next.st = ST_TRIP;
    end

    // disabling drops back to pass-through
    if (!enabled && (core_reg.st != ST_IDLE) && (core_reg.st != ST_TRIP)) begin
      core_next.st = ST_IDLE;
    end

    // outputs from the state being entered
    case (core_next.st)
      ST_IDLE: begin
        core_next.brake_rel = 1'b0;
        core_next.brake_err = 1'b0;
        core_next.drive_run = !enabled && run_cmd;
        core_next.freq_target = enabled ? FREQ_RST : freq_cmd;
      end
      ST_RAMP_REL, ST_REL_WAIT, ST_CONF_ON, ST_ACC_WAIT: begin
        core_next.drive_run = 1'b1;
        core_next.freq_target = core_reg.release_frequency;
      end
      ST_RUNNING: begin
        core_next.drive_run = 1'b1;
        core_next.freq_target = freq_cmd;
      end
      ST_DECEL_BRK, ST_CONF_OFF, ST_STOP_WAIT: begin
        core_next.drive_run = 1'b1;
        core_next.freq_target = core_reg.braking_frequency;
      end
      ST_STOP_DECEL: begin
        core_next.brake_rel = 1'b0;
        core_next.drive_run = 1'b1;
        core_next.freq_target = FREQ_RST;
      end
      ST_TRIP: begin
        core_next.brake_rel = 1'b0;
        core_next.brake_err = 1'b1;
        core_next.drive_run = 1'b0;
        core_next.freq_target = FREQ_RST;
      end
      default: begin
        core_next.drive_run = 1'b0;
        core_next.freq_target = FREQ_RST;
      end
    endcase

    // events: set wins over write-one clear
    ev[INT_REL_ON] = core_next.brake_rel & ~core_reg.brake_rel;
    ev[INT_REL_OFF] = ~core_next.brake_rel & core_reg.brake_rel;
    ev[INT_TRIP] = (core_next.st == ST_TRIP) && (core_reg.st != ST_TRIP);
    core_next.int_stat = (core_reg.int_stat & ~w1c) | ev;

    // output terminal routing
    core_next.term_out = (out_is_rel & {N_OUT{core_next.brake_rel}}) |
                         (out_is_err & {N_OUT{core_next.brake_err}});

    // read data captured in the setup phase
    if (setup) begin
      core_next.prdata = rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      core_reg <= CORE_RST;
    end else if (ce) begin
      core_reg <= core_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clamp a written wait time to the settable range
  function automatic logic [8:0] wait_clamp(input logic [31:0] wdata);
    if (wdata > {23'h000000, WAIT_MAX}) begin
      return WAIT_MAX;
    end
    return wdata[8:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign apb_rsp.prdata = core_reg.prdata;
  assign apb_rsp.pready = ce;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~addr_hit;
  assign drive_run = core_reg.drive_run;
  assign freq_target = core_reg.freq_target;
  assign brake_release_out = core_reg.brake_rel;
  assign brake_error_out = core_reg.brake_err;
  assign term_out = core_reg.term_out;
  assign irq = |(core_reg.int_stat & core_reg.int_mask);

endmodule // ebs_seq
`default_nettype wire

// ==== ebs_seq_chk.sv ====
// port assertions of the brake sequencer
`default_nettype none
module ebs_seq_chk #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire ebs_pkg::ebs_apb_req_t apb_req,
  input wire ebs_pkg::ebs_apb_rsp_t apb_rsp,
  input wire logic run_cmd,
  input wire logic [15:0] freq_cmd,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] out_current,
  input wire logic [7:0] term_in,
  input wire logic drive_run,
  input wire logic [15:0] freq_target,
  input wire logic brake_release_out,
  input wire logic brake_error_out,
  input wire logic [4:0] term_out,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import ebs_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  logic clr_wr;
  assign clr_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == OFS_CTRL
    && apb_req.pwdata[CTRL_TRIP_CLR_BIT];
  sequence s_rel_on;
    $rose(brake_release_out);
  endsequence
  sequence s_rel_off;
    $fell(brake_release_out) ##0 !brake_error_out;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_trip_safe_out: assert property (brake_error_out |-> !brake_release_out && !drive_run && freq_target == 16'h0)
    else $error("trip with release or drive active");
  a_trip_sticky: assert property (brake_error_out && !clr_wr |=> brake_error_out)
    else $error("error dropped without clear");
  a_rel_at_freq: assert property (s_rel_on |-> drive_run && $past(out_freq) >= $past(freq_target))
    else $error("release before release frequency");
  a_rel_holds_freq: assert property (s_rel_on |-> $stable(freq_target))
    else $error("frequency moved at release");
  a_rel_off_freq: assert property (s_rel_off |-> $past(out_freq) <= $past(freq_target))
    else $error("release dropped above braking frequency");
  a_run_start: assert property ($rose(drive_run) |-> $past(run_cmd))
    else $error("output started without run");
  a_apb_ready: assert property (apb_req.psel && apb_req.penable |-> apb_rsp.pready == ce ##1 $stable(apb_rsp.prdata))
    else $error("ready wrong or read data moved after access");
  a_apb_unmapped: assert property (apb_req.psel && apb_req.penable && apb_req.paddr > OFS_INT_MASK |-> apb_rsp.pslverr)
    else $error("no slave error on unmapped address");
endmodule // ebs_seq_chk

bind ebs_seq ebs_seq_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.mclk(mclk), .rst_b(rst_b), .ce(ce),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .run_cmd(run_cmd), .freq_cmd(freq_cmd), .out_freq(out_freq),
  .out_current(out_current), .term_in(term_in), .drive_run(drive_run), .freq_target(freq_target),
  .brake_release_out(brake_release_out), .brake_error_out(brake_error_out), .term_out(term_out), .irq(irq));
`default_nettype wire

// ==== ebs_seq_test.sv ====
// self-checking bench of the brake sequencer
`default_nettype none
module ebs_seq_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ebs_pkg::*;
  localparam int unsigned TK = 4;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  ebs_apb_req_t req = '0;
  ebs_apb_rsp_t rsp;
  logic run_cmd = 1'b0;
  logic ce = 1'b1;
  logic [15:0] freq_cmd = 16'h01f4;
  logic [15:0] out_freq = 16'h0;
  logic [15:0] out_current = 16'h0;
  logic [1:0] brk_mode = 2'h0;
  logic confirm, drive_run, brake_release_out, brake_error_out, irq, e;
  logic [15:0] freq_target;
  logic [4:0] term_out;
  logic [31:0] q;
  int n;
  int errors = 0;
  int n_tests = 0;
  always #5 mclk = ~mclk;
  // motor follows its target at once, full torque from standstill
  always @(posedge mclk) out_freq <= freq_target;
  ebs_seq #(.TICK_CYCLES(TK)) i_dut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .apb_req(req), .apb_rsp(rsp),
    .run_cmd(run_cmd), .freq_cmd(freq_cmd), .out_freq(out_freq), .out_current(out_current),
    .term_in({7'h00, confirm}), .drive_run(drive_run), .freq_target(freq_target),
    .brake_release_out(brake_release_out), .brake_error_out(brake_error_out), .term_out(term_out), .irq(irq));
  ebs_brake_model i_brake (.mclk(mclk), .release_cmd(brake_release_out), .mode(brk_mode), .confirm(confirm));
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk);
    req.penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (rsp.pready === 1'b1) break;
    end
    // taken at the edge that completes the access
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(negedge mclk);
    if (i == 50) begin
      errors++;
      test_done();
    end
  endtask
  task automatic wait_on(input int s, input logic [15:0] v);
    logic [15:0] cur;
    for (n = 0; n < 3000; n++) begin
      @(negedge mclk);
      case (s)
        0: cur = brake_release_out;
        1: cur = brake_error_out;
        2: cur = drive_run;
        default: cur = freq_target;
      endcase
      if (cur === v) return;
    end
    errors++;
    test_done();
  endtask
  task automatic run(input logic r);
    @(posedge mclk);
    run_cmd <= r;
  endtask
  task automatic cfg(input logic asg, input logic [15:0] cur, input logic [1:0] m);
    apb(1'b1, OFS_CTRL, 32'h1);
    for (int k = 0; k < 4; k++) apb(1'b1, OFS_REL_WAIT + 8'(4 * k), 32'h3);
    apb(1'b1, OFS_REL_FREQ, 32'h64);
    apb(1'b1, OFS_REL_CUR, 32'h32);
    apb(1'b1, OFS_BRK_FREQ, 32'h50);
    apb(1'b1, OFS_IN_FN_LO, asg ? 32'h2c : 32'h0);
    apb(1'b1, OFS_OUT_FN, 32'h513);
    apb(1'b1, OFS_INT_MASK, 32'hf);
    @(posedge mclk);
    out_current <= cur;
    brk_mode <= m;
  endtask
  task automatic clr();
    run(1'b0);
    chk(irq, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h101);
    chk(brake_error_out, 1'b0);
    apb(1'b1, OFS_INT_STAT, 32'hf);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q, 32'h1);
    apb(1'b1, OFS_REL_WAIT, 32'h258);
    apb(1'b0, OFS_REL_WAIT, 32'h0);
    chk(q, 32'h1f4);
    apb(1'b0, 8'h3c, 32'h0);
    chk({q[30:0], e}, 32'h1);
  endtask
  task automatic t_bypass();
    run(1'b1);
    repeat (3) @(negedge mclk);
    chk({drive_run, brake_release_out, freq_target}, {2'b10, 16'h01f4});
    // clock enable low freezes the outputs
    @(posedge mclk);
    ce <= 1'b0;
    run_cmd <= 1'b0;
    repeat (3) @(negedge mclk);
    chk(drive_run, 1'b1);
    @(posedge mclk);
    ce <= 1'b1;
    wait_on(2, 16'h0);
  endtask
  task automatic t_normal();
    cfg(1'b1, 16'h3c, 2'h0);
    run(1'b1);
    wait_on(0, 16'h1);
    chk({term_out[0], freq_target}, {1'b1, 16'h64});
    wait_on(3, 16'h1f4);
    chk(32'(n > 3 * TK + 4), 32'h1);
    chk(irq, 1'b1);
    apb(1'b1, OFS_INT_MASK, 32'h0);
    chk(irq, 1'b0);
    apb(1'b1, OFS_INT_STAT, 32'h1);
    apb(1'b0, OFS_INT_STAT, 32'h0);
    chk(q, 32'h0);
    run(1'b0);
    wait_on(0, 16'h0);
    chk(freq_target, 16'h50);
    wait_on(2, 16'h0);
    chk(32'(n > 3 * TK), 32'h1);
    apb(1'b0, OFS_INT_STAT, 32'h0);
    chk({brake_error_out, q}, 33'ha);
  endtask
  task automatic t_lowcur();
    cfg(1'b1, 16'h0a, 2'h0);
    run(1'b1);
    wait_on(1, 16'h1);
    chk({brake_release_out, term_out[1:0], drive_run}, 4'b0100);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q[10:0], 11'h400);
    clr();
  endtask
  task automatic t_faults();
    cfg(1'b1, 16'h3c, 2'h1);
    run(1'b1);
    wait_on(1, 16'h1);
    clr();
    cfg(1'b1, 16'h3c, 2'h0);
    run(1'b1);
    wait_on(3, 16'h1f4);
    brk_mode <= 2'h1;
    wait_on(1, 16'h1);
    chk(32'(n < 5), 32'h1);
    clr();
    cfg(1'b1, 16'h3c, 2'h2);
    run(1'b1);
    wait_on(3, 16'h1f4);
    run(1'b0);
    wait_on(1, 16'h1);
    clr();
  endtask
  task automatic t_open();
    cfg(1'b0, 16'h3c, 2'h1);
    run(1'b1);
    wait_on(0, 16'h1);
    wait_on(3, 16'h1f4);
    chk(32'(n <= 3 * TK + 4 && !brake_error_out), 32'h1);
    run(1'b0);
    wait_on(0, 16'h0);
    wait_on(2, 16'h0);
    chk(32'(n <= 3 * TK + 6 && !brake_error_out), 32'h1);
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs();
    t_bypass();
    t_normal();
    t_lowcur();
    t_faults();
    t_open();
    test_done();
  end
endmodule // ebs_seq_test
`default_nettype wire

// ==== ebs_wait_timer.sv ====
// wait-phase timer counting 10 ms ticks up to a limit
`default_nettype none
module ebs_wait_timer #(
  parameter int unsigned TICK_CYCLES = ebs_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic restart,
  input wire logic halt,
  input wire logic [8:0] limit,
  output logic done
);
  import ebs_pkg::*;

  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);
  localparam ebs_tmr_t TMR_RST = '{pre: '0, ticks: WAIT_RST};

  ebs_tmr_t tmr_reg;
  ebs_tmr_t tmr_next;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    tmr_next = tmr_reg;
    if (restart) begin
      tmr_next.pre = '0;
      tmr_next.ticks = WAIT_RST;
    end else if (!halt && (tmr_reg.ticks < limit)) begin
      if (tmr_reg.pre == PRE_LAST) begin
        tmr_next.pre = '0;
        tmr_next.ticks = tmr_reg.ticks + 9'h001;
      end else begin
        tmr_next.pre = tmr_reg.pre + PRE_W'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tmr_reg <= TMR_RST;
    end else if (ce) begin
      tmr_reg <= tmr_next;
    end
  end

  assign done = (tmr_reg.ticks >= limit);

endmodule // ebs_wait_timer
`default_nettype wire
